// file: rx_signal_measurement.sv
// Operation
// - entering receive mode starts in enabled state, awaiting preamble or RSSI detection
// - once detection is met, go active and hand signal to packet engine
// - five ascending input thresholds pick one of six gain codes 001..111
// - rssi_reading is minus two times input dBm plus correction
// - rssi_correction is signed, -16 to +15 dB, added to the reading
// - average count code selects 2 to 256 samples, two to code plus one
// - response time follows sample count over four times filter width
// - RSSI calibration changes only when calibration is launched
// - packet level averages instant level; instant level readable anytime
// - instant level refreshes every reciprocal of signal bandwidth
// - channel filter is a sixteen-tap FIR in the decimation chain
// - filter width from mantissa 16/20/24 and exponent 1..7, others reserved
// - temperature monitor runs outside sleep and standby unless disabled
// - each finished temperature conversion lands in temp_reading
`timescale 1ns/1ps
module rx_signal_measurement import rx_meas_pkg::*; #(
  parameter int TEMP_PERIOD = TEMP_PERIOD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire reg_req_type reg_req,
  output logic [7:0] rd_data,
  // front end
  input wire front_end_type fe_in,
  input wire logic [2:0] op_mode,
  input wire logic modem_spread,
  input wire logic preamble_found,
  input wire logic rx_restart,
  // spread-spectrum demodulator
  input wire logic header_valid_flag,
  input wire logic receive_done_flag,
  input wire logic [7:0] snr_estimate,
  // temperature sensor
  input wire logic temp_done,
  input wire logic [7:0] temp_code,
  output logic temp_start,
  // receiver outputs
  output logic [2:0] lna_gain_code,
  output logic rx_enabled,
  output logic rx_active,
  output logic cal_tone_on,
  output logic handoff_valid,
  output logic [15:0] handoff_data
);
  localparam int TW = $clog2(TEMP_PERIOD + 1);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [2:0] gain_step(input logic [7:0] rd, input logic [4:0][7:0] thr);
    logic [2:0] idx;
    idx = 3'h5;
    for (int i = 4; i >= 0; i--) begin
      if (rd >= thr[i]) begin
        idx = 3'(i);
      end
    end
    return LNA_GAIN_STEP[idx];
  endfunction

  function automatic logic [7:0] sat8(input logic signed [10:0] v);
    if (v < 0) begin
      return 8'h00;
    end else if (v > 11'sd255) begin
      return 8'hff;
    end
    return v[7:0];
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] rssi_cfg_r;
  logic [7:0] rssi_thresh_r;
  logic [7:0] filt_r;
  logic [7:0] spread_bw_r;
  logic [4:0][7:0] agc_thr_r;
  logic temp_off_r;
  logic cal_busy_r;
  logic signed [8:0] cal_trim_r;
  logic [7:0] rssi_reading_r;
  logic rssi_valid_r;
  logic [7:0] inst_level_r;
  logic [7:0] pkt_avg_r;
  logic [7:0] packet_level_r;
  logic [7:0] packet_snr_r;
  logic [7:0] temp_reading_r;
  rx_state_type rx_st_r;
  rx_state_type rx_nxt;

  logic [2:0] avg_code;
  logic [4:0] corr;
  logic [8:0] win;
  logic [3:0] win_shift;
  logic wr_hit;
  logic cfg_restart;
  logic cal_launch;
  logic [1:0] new_mant;
  logic [2:0] new_exp;

  assign avg_code = rssi_cfg_r[AVG_LSB +: 3];
  assign corr = rssi_cfg_r[CORR_LSB +: 5];
  assign win_shift = 4'(avg_code) + 4'h1;
  assign win = 9'h001 << win_shift;
  assign wr_hit = reg_req.we;
  assign cfg_restart = wr_hit && reg_req.addr == ADDR_RSSI_CONFIG
    && reg_req.wdata[AVG_LSB +: 3] != avg_code;
  assign cal_launch = wr_hit && reg_req.addr == ADDR_CONTROL && reg_req.wdata[CTRL_CAL];
  assign new_mant = reg_req.wdata[MANT_LSB +: 2];
  assign new_exp = reg_req.wdata[EXP_LSB +: 3];

  always_ff @(posedge clk) begin
    if (srst) begin
      rssi_cfg_r <= RST_RSSI_CONFIG;
      rssi_thresh_r <= RST_RSSI_THRESH;
      filt_r <= RST_FILTER_WIDTH;
      spread_bw_r <= RST_SPREAD_BW;
      agc_thr_r <= RST_AGC_THR;
      temp_off_r <= 1'b0;
    end else if (wr_hit) begin
      case (reg_req.addr)
        ADDR_RSSI_CONFIG: rssi_cfg_r <= reg_req.wdata;
        ADDR_RSSI_THRESH: rssi_thresh_r <= reg_req.wdata;
        ADDR_FILTER_WIDTH: begin
          // reserved settings are ignored
          if (new_mant != MANT_RESERVED && new_exp != EXP_RESERVED) begin
            filt_r <= {3'h0, new_mant, new_exp};
          end
        end
        ADDR_SPREAD_BW: spread_bw_r <= {6'h00, reg_req.wdata[1:0]};
        ADDR_CONTROL: temp_off_r <= reg_req.wdata[CTRL_TEMP_OFF];
        default: begin
          if (reg_req.addr >= ADDR_AGC_THR1 && reg_req.addr <= ADDR_AGC_THR5) begin
            agc_thr_r[3'(reg_req.addr - ADDR_AGC_THR1)] <= reg_req.wdata;
          end
        end
      endcase
    end
  end

  a_filt_legal: assert property (@(posedge clk) disable iff (srst)
    filt_r[MANT_LSB +: 2] != MANT_RESERVED && filt_r[EXP_LSB +: 3] != EXP_RESERVED)
    else $error("filter width holds a reserved setting");

  // ----------------------------------------
  // channel filter and decimation
  // ----------------------------------------
  logic [15:0] fir_out;
  logic fir_valid;
  logic [11:0] dec_ratio;
  logic [11:0] dec_cnt_r;
  logic dec_tick;

  channel_fir #(.DW(12), .TAPS(FIR_TAPS)) u_fir (
    .clk(clk),
    .srst(srst),
    .in_sample(fe_in.sample),
    .in_valid(fe_in.sample_valid),
    .out_sample(fir_out),
    .out_valid(fir_valid)
  );

  // ratio = mantissa * 2^exp; width = crystal / (4 * ratio)
  always_comb begin
    case (filt_r[MANT_LSB +: 2])
      2'h0: dec_ratio = MANT_VAL_0 << filt_r[EXP_LSB +: 3];
      2'h1: dec_ratio = MANT_VAL_1 << filt_r[EXP_LSB +: 3];
      default: dec_ratio = MANT_VAL_2 << filt_r[EXP_LSB +: 3];
    endcase
  end

  assign dec_tick = fir_valid && dec_cnt_r >= dec_ratio - 12'h001;

  always_ff @(posedge clk) begin
    if (srst) begin
      dec_cnt_r <= '0;
    end else if (dec_tick) begin
      dec_cnt_r <= '0;
    end else if (fir_valid) begin
      dec_cnt_r <= dec_cnt_r + 12'h001;
    end
  end

  // ----------------------------------------
  // corrected level and calibration
  // ----------------------------------------
  logic signed [10:0] lvl_sum;
  logic [7:0] level_corr;

  // reading = -2 * dBm + correction, plus calibration trim
  assign lvl_sum = $signed({3'b000, fe_in.level}) + 11'(cal_trim_r) + 11'($signed(corr));
  assign level_corr = sat8(lvl_sum);

  always_ff @(posedge clk) begin
    if (srst) begin
      cal_busy_r <= 1'b0;
      cal_trim_r <= '0;
    end else begin
      if (cal_busy_r && dec_tick) begin
        cal_busy_r <= 1'b0;
        cal_trim_r <= $signed({1'b0, CAL_REF_LEVEL}) - $signed({1'b0, fe_in.level});
      end
      if (cal_launch) begin
        cal_busy_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cal_tone_on <= 1'b0;
    end else begin
      cal_tone_on <= cal_busy_r;
    end
  end

  a_cal_only_launch: assert property (@(posedge clk) disable iff (srst)
    cal_trim_r != $past(cal_trim_r) |-> $past(cal_busy_r) && $past(dec_tick))
    else $error("calibration trim moved without a launch");

  // ----------------------------------------
  // rssi smoothing window
  // ----------------------------------------
  logic [7:0] pend_r;
  logic pend_v_r;
  logic [7:0] wr_ptr_r;
  logic [8:0] fill_r;
  logic [15:0] sum_r;
  logic [15:0] sum_nxt;
  logic [7:0] old_sample;
  logic win_full;

  window_mem #(.DW(8), .DEPTH(256)) u_win (
    .clk(clk),
    .srst(srst),
    .we(pend_v_r),
    .waddr(wr_ptr_r),
    .wdata(pend_r),
    .raddr(wr_ptr_r - win[7:0]),
    .rdata(old_sample)
  );

  assign win_full = fill_r == win;
  assign sum_nxt = sum_r + 16'(pend_r) - (win_full ? 16'(old_sample) : 16'h0000);

  // one sample per decimated output paces the response time
  always_ff @(posedge clk) begin
    if (srst || cfg_restart) begin
      pend_r <= '0;
      pend_v_r <= 1'b0;
    end else begin
      pend_v_r <= dec_tick && !cal_busy_r;
      if (dec_tick) begin
        pend_r <= level_corr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst || cfg_restart) begin
      sum_r <= '0;
      fill_r <= '0;
      wr_ptr_r <= '0;
      rssi_valid_r <= 1'b0;
      rssi_reading_r <= '0;
    end else if (pend_v_r) begin
      sum_r <= sum_nxt;
      wr_ptr_r <= wr_ptr_r + 8'h01;
      if (!win_full) begin
        fill_r <= fill_r + 9'h001;
      end
      if (win_full || fill_r + 9'h001 == win) begin
        rssi_valid_r <= 1'b1;
        rssi_reading_r <= 8'(sum_nxt >> win_shift);
      end
    end
  end

  a_window_publish: assert property (@(posedge clk) disable iff (srst)
    pend_v_r && !cfg_restart && fill_r == win - 9'h001 |=> rssi_valid_r)
    else $error("reading not published when window filled");

  a_window_wait: assert property (@(posedge clk) disable iff (srst)
    !rssi_valid_r && fill_r < win - 9'h001 |=> !rssi_valid_r)
    else $error("reading published before window filled");

  // ----------------------------------------
  // gain control
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      lna_gain_code <= LNA_GAIN_STEP[0];
    end else if (rssi_valid_r) begin
      lna_gain_code <= gain_step(rssi_reading_r, agc_thr_r);
    end else begin
      lna_gain_code <= LNA_GAIN_STEP[0];
    end
  end

  a_gain_weak: assert property (@(posedge clk) disable iff (srst)
    rssi_valid_r && rssi_reading_r >= agc_thr_r[0] |=> lna_gain_code == 3'h1)
    else $error("weak input did not select the top gain code");

  a_gain_strong: assert property (@(posedge clk) disable iff (srst)
    rssi_valid_r && rssi_reading_r < agc_thr_r[4] && rssi_reading_r < agc_thr_r[3]
    && rssi_reading_r < agc_thr_r[2] && rssi_reading_r < agc_thr_r[1]
    && rssi_reading_r < agc_thr_r[0] |=> lna_gain_code == 3'h7)
    else $error("strong input did not select the lowest gain code");

  // ----------------------------------------
  // receiver states
  // ----------------------------------------
  always_comb begin
    rx_nxt = rx_st_r;
    case (rx_st_r)
      RX_OFF: begin
        if (op_mode == MODE_RX) begin
          rx_nxt = RX_ENABLED;
        end
      end
      RX_ENABLED: begin
        if (op_mode != MODE_RX) begin
          rx_nxt = RX_OFF;
        end else if (preamble_found || (rssi_valid_r && rssi_reading_r <= rssi_thresh_r)) begin
          rx_nxt = RX_ACTIVE;
        end
      end
      RX_ACTIVE: begin
        if (op_mode != MODE_RX) begin
          rx_nxt = RX_OFF;
        end else if (rx_restart) begin
          rx_nxt = RX_ENABLED;
        end
      end
      default: rx_nxt = RX_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_st_r <= RX_OFF;
      rx_enabled <= 1'b0;
      rx_active <= 1'b0;
    end else begin
      rx_st_r <= rx_nxt;
      rx_enabled <= rx_nxt == RX_ENABLED;
      rx_active <= rx_nxt == RX_ACTIVE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      handoff_valid <= 1'b0;
      handoff_data <= '0;
    end else begin
      handoff_valid <= dec_tick && rx_st_r == RX_ACTIVE;
      handoff_data <= fir_out;
    end
  end

  a_rx_enter_enabled: assert property (@(posedge clk) disable iff (srst)
    rx_st_r == RX_OFF && op_mode == MODE_RX |=> rx_enabled && !rx_active)
    else $error("receive mode did not start in the enabled state");

  a_rx_go_active: assert property (@(posedge clk) disable iff (srst)
    rx_st_r == RX_ENABLED && op_mode == MODE_RX && preamble_found |=> rx_active)
    else $error("detection did not activate the receiver");

  // ----------------------------------------
  // spread-spectrum signal levels
  // ----------------------------------------
  logic [9:0] ref_cnt_r;
  logic [9:0] ref_load;
  logic refresh_tick;
  logic in_pkt_r;

  always_comb begin
    case (spread_bw_r[1:0])
      2'h0: ref_load = 10'(REFRESH_CYC_125 - 1);
      2'h1: ref_load = 10'(REFRESH_CYC_250 - 1);
      default: ref_load = 10'(REFRESH_CYC_500 - 1);
    endcase
  end

  assign refresh_tick = ref_cnt_r == 10'h000;

  // instant level refreshed once per reciprocal bandwidth
  always_ff @(posedge clk) begin
    if (srst) begin
      ref_cnt_r <= '0;
      inst_level_r <= '0;
    end else begin
      ref_cnt_r <= refresh_tick ? ref_load : ref_cnt_r - 10'h001;
      if (refresh_tick) begin
        inst_level_r <= level_corr;
      end
    end
  end

  // packet level is a running average over the packet
  always_ff @(posedge clk) begin
    if (srst) begin
      in_pkt_r <= 1'b0;
      pkt_avg_r <= '0;
      packet_level_r <= '0;
      packet_snr_r <= '0;
    end else if (modem_spread) begin
      if (header_valid_flag) begin
        in_pkt_r <= 1'b1;
        pkt_avg_r <= inst_level_r;
      end else if (in_pkt_r && refresh_tick) begin
        pkt_avg_r <= 8'(({3'b000, pkt_avg_r} * 11'd7 + {3'b000, inst_level_r}) >> PKT_AVG_SHIFT);
      end
      if (receive_done_flag) begin
        in_pkt_r <= 1'b0;
        packet_level_r <= pkt_avg_r;
        packet_snr_r <= snr_estimate;
      end
    end
  end

  a_refresh_gap: assert property (@(posedge clk) disable iff (srst)
    refresh_tick && spread_bw_r[1:0] == 2'h2 |=> !refresh_tick [*8])
    else $error("instant level refreshed too early");

  // ----------------------------------------
  // temperature monitor
  // ----------------------------------------
  logic temp_en;
  logic [TW-1:0] temp_cnt_r;

  assign temp_en = !temp_off_r && op_mode != MODE_SLEEP && op_mode != MODE_STANDBY;

  always_ff @(posedge clk) begin
    if (srst) begin
      temp_cnt_r <= '0;
      temp_start <= 1'b0;
    end else if (!temp_en) begin
      temp_cnt_r <= '0;
      temp_start <= 1'b0;
    end else begin
      temp_start <= temp_cnt_r == TW'(TEMP_PERIOD - 1);
      temp_cnt_r <= temp_cnt_r == TW'(TEMP_PERIOD - 1) ? '0 : temp_cnt_r + TW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      temp_reading_r <= '0;
    end else if (temp_done) begin
      temp_reading_r <= temp_code;
    end
  end

  a_temp_stopped: assert property (@(posedge clk) disable iff (srst)
    !temp_en |=> !temp_start)
    else $error("temperature conversion started while stopped");

  a_temp_store: assert property (@(posedge clk) disable iff (srst)
    temp_done ##1 !temp_done [*2] |-> temp_reading_r == $past(temp_code, 2))
    else $error("conversion result not stored");

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
    end else if (reg_req.re) begin
      case (reg_req.addr)
        ADDR_RSSI_CONFIG: rd_data <= rssi_cfg_r;
        ADDR_RSSI_THRESH: rd_data <= rssi_thresh_r;
        ADDR_RSSI_READING: rd_data <= rssi_reading_r;
        ADDR_FILTER_WIDTH: rd_data <= filt_r;
        ADDR_STATUS: rd_data <= {1'b0, rssi_valid_r, cal_busy_r, rx_active, rx_enabled,
          lna_gain_code};
        ADDR_CONTROL: rd_data <= {6'h00, cal_busy_r, temp_off_r};
        ADDR_INSTANT: rd_data <= inst_level_r;
        ADDR_PACKET: rd_data <= packet_level_r;
        ADDR_PACKET_SNR: rd_data <= packet_snr_r;
        ADDR_TEMP: rd_data <= temp_reading_r;
        ADDR_SPREAD_BW: rd_data <= spread_bw_r;
        default: begin
          if (reg_req.addr >= ADDR_AGC_THR1 && reg_req.addr <= ADDR_AGC_THR5) begin
            rd_data <= agc_thr_r[3'(reg_req.addr - ADDR_AGC_THR1)];
          end else begin
            rd_data <= 8'h00;
          end
        end
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule

// file: rx_meas_pkg.sv
package rx_meas_pkg;
  localparam int CLK_MHZ = 100;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_RSSI_CONFIG = 8'h0e;
  localparam logic [7:0] ADDR_RSSI_THRESH = 8'h10;
  localparam logic [7:0] ADDR_RSSI_READING = 8'h11;
  localparam logic [7:0] ADDR_FILTER_WIDTH = 8'h12;
  localparam logic [7:0] ADDR_AGC_THR1 = 8'h20;
  localparam logic [7:0] ADDR_AGC_THR5 = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h25;
  localparam logic [7:0] ADDR_CONTROL = 8'h26;
  localparam logic [7:0] ADDR_INSTANT = 8'h27;
  localparam logic [7:0] ADDR_PACKET = 8'h28;
  localparam logic [7:0] ADDR_PACKET_SNR = 8'h29;
  localparam logic [7:0] ADDR_TEMP = 8'h2a;
  localparam logic [7:0] ADDR_SPREAD_BW = 8'h2b;
  // ----------------------------------------
  // reset values and fields
  // ----------------------------------------
  localparam logic [7:0] RST_RSSI_CONFIG = 8'h02;
  localparam logic [7:0] RST_RSSI_THRESH = 8'hff;
  localparam logic [7:0] RST_FILTER_WIDTH = 8'h15;
  localparam logic [7:0] RST_SPREAD_BW = 8'h00;
  localparam logic [4:0][7:0] RST_AGC_THR = {8'h50, 8'h64, 8'h78, 8'h8c, 8'ha0};
  localparam int CORR_LSB = 3;
  localparam int AVG_LSB = 0;
  localparam int MANT_LSB = 3;
  localparam int EXP_LSB = 0;
  localparam int CTRL_TEMP_OFF = 0;
  localparam int CTRL_CAL = 1;
  localparam logic [1:0] MANT_RESERVED = 2'h3;
  localparam logic [2:0] EXP_RESERVED = 3'h0;
  localparam logic [11:0] MANT_VAL_0 = 12'h010;
  localparam logic [11:0] MANT_VAL_1 = 12'h014;
  localparam logic [11:0] MANT_VAL_2 = 12'h018;
  localparam logic [5:0][2:0] LNA_GAIN_STEP = {3'h7, 3'h6, 3'h4, 3'h3, 3'h2, 3'h1};
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int REFRESH_NS_125 = 8000;
  localparam int REFRESH_NS_250 = 4000;
  localparam int REFRESH_NS_500 = 2000;
  localparam int REFRESH_CYC_125 = REFRESH_NS_125 * CLK_MHZ / 1000;
  localparam int REFRESH_CYC_250 = REFRESH_NS_250 * CLK_MHZ / 1000;
  localparam int REFRESH_CYC_500 = REFRESH_NS_500 * CLK_MHZ / 1000;
  localparam int TEMP_PERIOD_US = 100;
  localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_US * CLK_MHZ;
  // ----------------------------------------
  // misc constants
  // ----------------------------------------
  localparam logic [7:0] CAL_REF_LEVEL = 8'h80;
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_RX = 3'h5;
  localparam int PKT_AVG_SHIFT = 3;
  localparam int FIR_TAPS = 16;
  localparam logic [15:0][7:0] FIR_COEF = {8'h02, 8'h04, 8'h08, 8'h0e, 8'h16, 8'h1e, 8'h26,
    8'h2a, 8'h2a, 8'h26, 8'h1e, 8'h16, 8'h0e, 8'h08, 8'h04, 8'h02};
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RX_OFF = 3'b001,
    RX_ENABLED = 3'b010,
    RX_ACTIVE = 3'b100
  } rx_state_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } reg_req_type;
  typedef struct packed {
    logic [11:0] sample;
    logic sample_valid;
    logic [7:0] level;
  } front_end_type;
endpackage

// file: window_mem.sv
`timescale 1ns/1ps
module window_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read side
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// file: channel_fir.sv
`timescale 1ns/1ps
module channel_fir import rx_meas_pkg::*; #(
  parameter int DW = 12,
  parameter int TAPS = FIR_TAPS
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // samples in
  input wire logic [DW-1:0] in_sample,
  input wire logic in_valid,
  // filtered samples out
  output logic [15:0] out_sample,
  output logic out_valid
);
  localparam int ACCW = DW + 12;
  logic signed [DW-1:0] taps_r [TAPS];
  logic signed [ACCW-1:0] acc;

  // sixteen-tap low-pass, symmetric coefficients
  always_comb begin
    acc = '0;
    for (int i = 0; i < TAPS; i++) begin
      acc = acc + ACCW'(taps_r[i] * $signed(FIR_COEF[i]));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < TAPS; i++) begin
        taps_r[i] <= '0;
      end
    end else if (in_valid) begin
      taps_r[0] <= $signed(in_sample);
      for (int i = 1; i < TAPS; i++) begin
        taps_r[i] <= taps_r[i-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_sample <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
      out_sample <= acc[ACCW-1 -: 16];
    end
  end
endmodule

// file: fe_model.sv
`timescale 1ns/1ps
module fe_model import rx_meas_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // stimulus level and sensor request
  input wire logic [7:0] level,
  input wire logic temp_start,
  // samples and sensor answer
  output front_end_type fe_out,
  output logic temp_done,
  output logic [7:0] temp_code
);
  logic [2:0] tcnt_r;
  // ----------------------------------------
  // adc samples, one every second cycle
  // ----------------------------------------
  always_ff @(posedge clk) begin
    fe_out.sample_valid <= srst ? 1'b0 : ~fe_out.sample_valid;
    fe_out.sample <= srst ? 12'h000 : fe_out.sample + 12'h155;
    fe_out.level <= level;
  end
  // ----------------------------------------
  // temperature sensor, answers four cycles after a request
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      tcnt_r <= 3'h0;
    end else if (temp_start) begin
      tcnt_r <= 3'h3;
    end else if (tcnt_r != 3'h0) begin
      tcnt_r <= tcnt_r - 3'h1;
    end
    temp_done <= !srst && tcnt_r == 3'h1;
    temp_code <= 8'h3c;
  end
endmodule

// file: rx_signal_measurement_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) checked++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: got %h exp %h", $time, a, b); end
module rx_signal_measurement_tb import rx_meas_pkg::*;;
  logic clk, srst, preamble_found, temp_start, temp_done, rx_enabled, rx_active;
  logic modem_spread, rx_restart, header_valid_flag, receive_done_flag, cal_tone_on;
  logic handoff_valid;
  logic [7:0] snr_estimate;
  logic [2:0] op_mode;
  logic [7:0] rd_data, temp_code, level, v;
  reg_req_type req;
  front_end_type fe;
  int fail_count, checked, i, n;
  rx_signal_measurement #(.TEMP_PERIOD(20)) uut (.clk(clk), .srst(srst), .reg_req(req),
    .rd_data(rd_data), .fe_in(fe), .op_mode(op_mode), .modem_spread(modem_spread),
    .preamble_found(preamble_found), .rx_restart(rx_restart),
    .header_valid_flag(header_valid_flag), .receive_done_flag(receive_done_flag),
    .snr_estimate(snr_estimate), .temp_done(temp_done),
    .temp_code(temp_code), .temp_start(temp_start), .lna_gain_code(), .rx_enabled(rx_enabled),
    .rx_active(rx_active), .cal_tone_on(cal_tone_on), .handoff_valid(handoff_valid),
    .handoff_data());
  fe_model fm (.clk(clk), .srst(srst), .level(level), .temp_start(temp_start), .fe_out(fe),
    .temp_done(temp_done), .temp_code(temp_code));
  // ----------------------------------------
  // register access
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk) req.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk) req.re <= 1'b0;
    @(posedge clk) d = rd_data;
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    req = '0;
    op_mode = MODE_STANDBY;
    preamble_found = 1'b0;
    modem_spread = 1'b0;
    rx_restart = 1'b0;
    header_valid_flag = 1'b0;
    receive_done_flag = 1'b0;
    snr_estimate = 8'h00;
    level = 8'h40;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_RSSI_CONFIG, v); `CHK(v, RST_RSSI_CONFIG)
    rd(ADDR_AGC_THR1, v); `CHK(v, 8'ha0)
    rd(ADDR_AGC_THR5, v); `CHK(v, 8'h50)
    rd(8'h00, v); `CHK(v, 8'h00)
    rd(ADDR_FILTER_WIDTH, v); `CHK(v, RST_FILTER_WIDTH)
    wr(ADDR_FILTER_WIDTH, 8'h19);
    wr(ADDR_FILTER_WIDTH, 8'h08);
    rd(ADDR_FILTER_WIDTH, v); `CHK(v, RST_FILTER_WIDTH)
    wr(ADDR_FILTER_WIDTH, 8'h09);
    rd(ADDR_FILTER_WIDTH, v); `CHK(v, 8'h09)
    // receiver states
    op_mode <= MODE_RX;
    repeat (3) @(posedge clk);
    `CHK({rx_enabled, rx_active}, 2'b10)
    preamble_found <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(rx_active, 1'b1)
    preamble_found <= 1'b0;
    rx_restart <= 1'b1;
    @(posedge clk) rx_restart <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({rx_enabled, rx_active}, 2'b10)
    // temperature conversion lands in its register
    n = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk) n += temp_start;
    end
    rd(ADDR_TEMP, v); `CHK(v, 8'h3c)
    `CHK(n > 0, 1'b1)
    wr(ADDR_CONTROL, 8'h01);
    @(posedge clk);
    n = 0;
    for (i = 0; i < 60; i++) begin
      @(posedge clk) n += temp_start;
    end
    `CHK(n, 0)
    // rssi average of two samples, then with a correction
    wr(ADDR_SPREAD_BW, 8'h02);
    wr(ADDR_RSSI_CONFIG, 8'h00);
    v = 8'h00;
    for (i = 0; i < 100 && v[6] !== 1'b1; i++) begin
      repeat (20) @(posedge clk);
      rd(ADDR_STATUS, v);
    end
    if (i == 100) begin
      fail_count++;
      report_and_stop();
    end
    rd(ADDR_STATUS, v);
    `CHK(v[2:0], 3'h7)
    rd(ADDR_RSSI_READING, v); `CHK(v, 8'h40)
    wr(ADDR_RSSI_CONFIG, 8'h10);
    repeat (600) @(posedge clk);
    rd(ADDR_RSSI_READING, v); `CHK(v, 8'h42)
    // calibration trims the level to the reference
    wr(ADDR_CONTROL, 8'h02);
    repeat (2) @(posedge clk);
    `CHK(cal_tone_on, 1'b1)
    n = 0;
    for (i = 0; i < 600; i++) begin
      @(posedge clk) n += handoff_valid;
    end
    `CHK(n > 5, 1'b1)
    rd(ADDR_RSSI_READING, v); `CHK(v, CAL_REF_LEVEL + 8'h02)
    rd(ADDR_STATUS, v); `CHK(v[2:0], 3'h3)
    // packet levels in spread-spectrum mode
    modem_spread <= 1'b1;
    snr_estimate <= 8'hf8;
    header_valid_flag <= 1'b1;
    @(posedge clk) header_valid_flag <= 1'b0;
    repeat (300) @(posedge clk);
    rd(ADDR_INSTANT, v); `CHK(v, CAL_REF_LEVEL + 8'h02)
    receive_done_flag <= 1'b1;
    @(posedge clk) receive_done_flag <= 1'b0;
    rd(ADDR_PACKET, v); `CHK(v, CAL_REF_LEVEL + 8'h02)
    rd(ADDR_PACKET_SNR, v); `CHK(v, 8'hf8)
    report_and_stop();
  end
endmodule
